// >>> dv/clock_supervisor_properties.sv
// Port checker for the clock supervisor
`timescale 1ns/100ps
module clock_supervisor_properties
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire clock_supervisor_pkg::clock_mode_t clock_mode,
   input wire logic cpu_clk_sel_pll,
   input wire logic cpu_clk,
   input wire logic pll_enable,
   input wire logic pll_multiply,
   input wire logic supervisor_irq
);
   import clock_supervisor_pkg::*;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   irq_sel_a: assert property (supervisor_irq |-> cpu_clk_sel_pll)
      else $error("no switch");
   irq_pulse_a: assert property (supervisor_irq |=> !supervisor_irq)
      else $error("long irq");
   sel_hold_a: assert property (cpu_clk_sel_pll |=> cpu_clk_sel_pll)
      else $error("switch lost");
   base_rate_a: assert property (cpu_clk_sel_pll |-> !pll_multiply)
      else $error("multiplied");
   off_quiet_a: assert property (!pll_enable |-> !supervisor_irq)
      else $error("irq when off");
   off_idle_a: assert property (!pll_enable |-> !cpu_clk_sel_pll)
      else $error("pll used when off");
   direct_rate_a: assert property (cpu_clk_sel_pll && clock_mode != MODE_PRESCALER |-> !cpu_clk)
      else $error("not direct");
   half_rate_a: assert property (cpu_clk_sel_pll && $past(cpu_clk_sel_pll)
      && clock_mode == MODE_PRESCALER |-> cpu_clk != $past(cpu_clk))
      else $error("not halved");
   cover property (supervisor_irq);
   cover property (!pll_enable ##8 !pll_enable);
   cover property (cpu_clk_sel_pll && clock_mode == MODE_PRESCALER);
endmodule : clock_supervisor_properties
bind clock_supervisor clock_supervisor_properties props (.core_clk(core_clk),
   .reset_n(reset_n), .clock_mode(clock_mode), .cpu_clk_sel_pll(cpu_clk_sel_pll),
   .cpu_clk(cpu_clk), .pll_enable(pll_enable), .pll_multiply(pll_multiply),
   .supervisor_irq(supervisor_irq));

// >>> dv/osc_model.sv
// Crystal oscillator that can be stopped
`timescale 1ns/100ps
module osc_model
(
   input wire logic run,
   output logic crystal_input
);
   // Well below half the supervisory rate
   initial
   begin
      crystal_input = 1'b0;
      forever
      begin
         #20;
         if (run)
            crystal_input = ~crystal_input;
      end
   end
endmodule : osc_model

// >>> dv/testbench.sv
// Bench for the clock supervisor
`timescale 1ns/100ps
module testbench;
   import clock_supervisor_pkg::*;
   logic core_clk, reset_n, strobe_n, run, xin, sel, cpu_clk, pll_en, pll_mul, irq;
   clock_mode_t mode = MODE_DIRECT;
   super_status_t status;
   int fail_count, n_checks, irq_count;
   osc_model osc (.run(run), .crystal_input(xin));
   clock_supervisor DUT (.core_clk(core_clk), .reset_n(reset_n), .read_strobe_n(strobe_n),
      .crystal_input(xin), .osc_path_clk(xin), .clock_mode(mode), .cpu_clk_sel_pll(sel),
      .cpu_clk(cpu_clk), .pll_enable(pll_en), .pll_multiply(pll_mul),
      .supervisor_irq(irq), .status(status));
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
      irq_count += (irq === 1'b1);
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("FAIL %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize;
      $display("checks %0d fails %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   task automatic start(input logic strap, input clock_mode_t m);
      @(posedge core_clk);
      reset_n <= 1'b0;
      strobe_n <= strap;
      mode <= m;
      run <= 1'b1;
      repeat (3) @(posedge core_clk);
      irq_count = 0;
      reset_n <= 1'b1;
      repeat (60) @(posedge core_clk);
   endtask : start
   task automatic lose_osc(input clock_mode_t m);
      logic c0;
      start(1'b1, m);
      @(negedge core_clk);
      check({irq_count[3:0], sel, pll_en, pll_mul, status.supervisor_disable}, 8'h06);
      check(status, 8'h02);
      @(posedge core_clk);
      run <= 1'b0;
      repeat (12) @(negedge core_clk);
      check(sel, 8'h00);
      repeat (18) @(negedge core_clk);
      check({irq_count[3:0], sel, pll_en, pll_mul, status.supervisor_disable}, 8'h1c);
      check(status, 8'h07);
      @(posedge core_clk);
      #1 c0 = cpu_clk;
      @(posedge core_clk);
      #1 check({c0, cpu_clk}, (m == MODE_PRESCALER) ? {6'h00, c0, ~c0} : 8'h03);
      @(posedge core_clk);
      run <= 1'b1;
      repeat (40) @(negedge core_clk);
      check({irq_count[3:0], sel, pll_mul}, 8'h06);
   endtask : lose_osc
   task automatic osc_off;
      start(1'b0, MODE_SLOWDOWN);
      @(negedge core_clk);
      check({sel, pll_en, pll_mul, status.supervisor_disable}, 8'h01);
      check(status, 8'h08);
      @(posedge core_clk);
      run <= 1'b0;
      repeat (60) @(negedge core_clk);
      check({irq_count[3:0], sel, pll_en}, 8'h00);
      @(posedge core_clk);
      run <= 1'b1;
      repeat (9) @(posedge core_clk);
      #1 check(cpu_clk, xin);
   endtask : osc_off
   initial
   begin
      reset_n = 1'b0;
      strobe_n = 1'b1;
      run = 1'b1;
      lose_osc(MODE_DIRECT);
      lose_osc(MODE_PRESCALER);
      lose_osc(MODE_SLOWDOWN);
      osc_off;
      summarize;
   end
   initial
   begin
      #20000;
      fail_count++;
      summarize;
   end
endmodule : testbench

// >>> hw/clock_supervisor.sv
// Oscillator clock supervisor with switchover to the PLL base clock
// Overview of operation
// - The oscillator clock is checked for transitions using the free-running PLL clock.
// - Missing transitions raise the supervisor interrupt and move the CPU onto the PLL clock.
// - After such a switch the PLL runs at its base frequency, not multiplied.
// - In direct-drive mode the PLL base clock feeds the CPU undivided.
// - In prescaler mode the PLL base clock is halved for the CPU.
// - The PLL source is kept until a hardware reset.
// - With the disable bit set the PLL idles and the CPU runs from the oscillator path.
// - With supervision disabled no interrupt is raised for a missing oscillator.
// - At reset end the disable bit takes the inverse of the read-strobe pin.
`timescale 1ns/100ps
module clock_supervisor
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic read_strobe_n,
   input wire logic crystal_input,
   input wire logic osc_path_clk,
   input wire clock_supervisor_pkg::clock_mode_t clock_mode,
   output logic cpu_clk_sel_pll,
   output logic cpu_clk,
   output logic pll_enable,
   output logic pll_multiply,
   output logic supervisor_irq,
   output clock_supervisor_pkg::super_status_t status
);
   import clock_supervisor_pkg::*;

   super_state_t state;
   super_state_t next_state;
   logic supervisor_disable;
   logic next_supervisor_disable;
   logic pll_half;
   logic next_pll_half;
   logic next_irq;
   logic osc_missing;
   logic watch_enable;
   super_status_t next_status;

   ////////////////////////////////////////////////////////////////////////////
   // State decodes shared by several processes
   function automatic logic is_failed(input super_state_t s);
      return s == ST_FAILED;
   endfunction : is_failed

   function automatic logic is_watching(input super_state_t s);
      return s == ST_WATCH;
   endfunction : is_watching

   function automatic logic is_off(input super_state_t s);
      return s == ST_OFF;
   endfunction : is_off

   ////////////////////////////////////////////////////////////////////////////
   // Edge watcher clocked by the PLL-derived supervisory clock
   assign watch_enable = is_watching(state);

   osc_edge_watch u_watch
   (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .enable(watch_enable),
      .osc_level(crystal_input),
      .osc_missing(osc_missing)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Supervisor state: strap capture, watching, failed or switched off
   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_STRAP:
         begin
            next_state = read_strobe_n ? ST_WATCH : ST_OFF;
         end
         ST_WATCH:
         begin
            if (osc_missing)
            begin
               next_state = ST_FAILED;
            end
         end
         ST_FAILED:
         begin
            next_state = ST_FAILED;
         end
         ST_OFF:
         begin
            next_state = ST_OFF;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= ST_STRAP;
      end
      else
      begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Disable bit, caught once from the read-strobe pin as reset ends
   always_comb
   begin
      next_supervisor_disable = supervisor_disable;
      if (state == ST_STRAP)
      begin
         next_supervisor_disable = ~read_strobe_n;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         supervisor_disable <= SUPERVISOR_DISABLE_RESET;
      end
      else
      begin
         supervisor_disable <= next_supervisor_disable;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // One-cycle request on the edge that moves the CPU onto the PLL
   always_comb
   begin
      next_irq = 1'b0;
      if (is_watching(state) && osc_missing && !supervisor_disable)
      begin
         next_irq = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         supervisor_irq <= 1'b0;
      end
      else
      begin
         supervisor_irq <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Halving toggle used in prescaler mode
   always_comb
   begin
      next_pll_half = pll_half;
      if (is_failed(state))
      begin
         next_pll_half = ~pll_half;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pll_half <= PLL_HALF_RESET;
      end
      else
      begin
         pll_half <= next_pll_half;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock selection; glitch-free muxing is left to the clock cell
   always_comb
   begin
      cpu_clk = osc_path_clk;
      if (is_failed(state))
      begin
         unique case (clock_mode)
            MODE_PRESCALER:
            begin
               cpu_clk = pll_half;
            end
            MODE_DIRECT,
            MODE_SLOWDOWN:
            begin
               cpu_clk = core_clk;
            end
            default:
            begin
               cpu_clk = core_clk;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Source and PLL controls, decoded from the one-hot state
   assign cpu_clk_sel_pll = is_failed(state);
   assign pll_enable = !is_off(state);
   assign pll_multiply = is_watching(state);

   // Status mirror, registered from the next state so it moves with the state
   always_comb
   begin
      next_status.supervisor_disable = next_supervisor_disable;
      next_status.on_pll = is_failed(next_state);
      next_status.pll_running = !is_off(next_state);
      next_status.pll_base_rate = is_failed(next_state);
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         status <= '{supervisor_disable: SUPERVISOR_DISABLE_RESET, on_pll: 1'b0,
                     pll_running: 1'b1, pll_base_rate: 1'b0};
      end
      else
      begin
         status <= next_status;
      end
   end

endmodule : clock_supervisor

// >>> hw/clock_supervisor_pkg.sv
// Package with modes, counts and carriers for the oscillator clock supervisor
package clock_supervisor_pkg;

   // Supervisory cycles without an oscillator edge before the clock is declared lost
   localparam int unsigned MISS_LIMIT = 16;
   localparam int unsigned MISS_WIDTH = 5;
   localparam logic [MISS_WIDTH-1:0] MISS_COUNT_RESET = 5'h0_0;
   localparam logic [MISS_WIDTH-1:0] MISS_COUNT_LIMIT = MISS_WIDTH'(MISS_LIMIT);

   // Value of the disable bit before the strap is caught
   localparam logic SUPERVISOR_DISABLE_RESET = 1'b0;
   localparam logic PLL_HALF_RESET = 1'b0;

   // CPU clock derivation modes
   typedef enum logic [1:0]
   {
      MODE_DIRECT = 2'h0,
      MODE_PRESCALER = 2'h1,
      MODE_SLOWDOWN = 2'h2
   } clock_mode_t;

   // Supervisor states, one-hot
   typedef enum logic [3:0]
   {
      ST_STRAP = 4'b0001,
      ST_WATCH = 4'b0010,
      ST_FAILED = 4'b0100,
      ST_OFF = 4'b1000
   } super_state_t;

   // Status reported to the system
   typedef struct packed
   {
      logic supervisor_disable;
      logic on_pll;
      logic pll_running;
      logic pll_base_rate;
   } super_status_t;

endpackage : clock_supervisor_pkg

// >>> hw/osc_edge_watch.sv
// Detector of missing oscillator edges, running on the supervisory clock
`timescale 1ns/100ps
module osc_edge_watch
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic enable,
   input wire logic osc_level,
   output logic osc_missing
);
   import clock_supervisor_pkg::*;

   logic osc_sync_a;
   logic osc_sync_b;
   logic osc_prev;
   logic [MISS_WIDTH-1:0] miss_count;
   logic [MISS_WIDTH-1:0] next_miss_count;
   logic next_osc_missing;
   logic edge_seen;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      edge_seen = osc_sync_b != osc_prev;
      next_miss_count = miss_count;
      next_osc_missing = 1'b0;
      if (!enable || edge_seen)
      begin
         next_miss_count = MISS_COUNT_RESET;
      end
      else if (miss_count != MISS_COUNT_LIMIT)
      begin
         next_miss_count = miss_count + 5'h0_1;
      end
      if (enable && !edge_seen && miss_count == MISS_COUNT_LIMIT)
      begin
         next_osc_missing = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         osc_sync_a <= 1'b0;
         osc_sync_b <= 1'b0;
         osc_prev <= 1'b0;
         miss_count <= MISS_COUNT_RESET;
         osc_missing <= 1'b0;
      end
      else
      begin
         osc_sync_a <= osc_level;
         osc_sync_b <= osc_sync_a;
         osc_prev <= osc_sync_b;
         miss_count <= next_miss_count;
         osc_missing <= next_osc_missing;
      end
   end

endmodule : osc_edge_watch
